// [hdl/trim_defines.svh]
`ifndef TRIM_DEFINES_SVH
`define TRIM_DEFINES_SVH

// Register indices; byte address is index shifted left
`define TRIM_IDX_LOW 8'h3c
`define TRIM_IDX_HIGH 8'h3d
`define TRIM_IDX_HOLD_LOW 8'h3e
`define TRIM_IDX_STATUS 8'h50
`define TRIM_IDX_PPM 8'h51
`define TRIM_ADDR_SHIFT 2

// Reset values
`define TRIM_RESET_BYTE 8'h99
`define HOLD_RESET_BYTE 8'h00

// Trim word layout
`define TRIM_HIGH_MSB 15
`define TRIM_HIGH_LSB 8
`define TRIM_LOW_MSB 7
`define TRIM_LOW_LSB 0

// Trim value that means zero offset (39321)
`define TRIM_NOMINAL 17'h09999

// Crystal nominal in kHz (12.8 MHz)
`define XTAL_NOMINAL_KHZ 14'h3200

// One LSB = 0.0196229 ppm; in Q16 ppm this is 1286
`define PPM_PER_LSB_Q16 13'sh0506

// One LSB of 12.8 MHz * 0.0196229 ppm = 0.251173 Hz; Q16 is 16461
`define HZ_PER_LSB_Q16 16'sh404d

// Whole-ppm bounds of the Q16 ppm after flooring: +514 and -771 (floors to -772)
`define PPM_MAX_INT 14'sh0202
`define PPM_MIN_INT 14'sh3cfc

// Status word bit positions
`define STATUS_VALID_BIT 31
`define STATUS_NOMINAL_BIT 30

`endif

// [hdl/trim_pkg.sv]
package trim_pkg;

    // Register byte
    typedef logic [7:0] byte_t;

    // Unsigned trim word
    typedef logic [15:0] trim_t;

    // Signed distance from nominal, one bit wider than the trim
    typedef logic signed [16:0] offset_t;

    // Offset in ppm, Q16
    typedef logic signed [29:0] ppm_t;

    // Offset in Hz at 12.8 MHz, Q16
    typedef logic signed [32:0] hz_t;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

endpackage

// [hdl/trim_if.sv]
`timescale 1ns/100ps

interface trim_if;
    trim_pkg::trim_t trim;
    trim_pkg::offset_t offset;
    trim_pkg::ppm_t ppm_q16;
    trim_pkg::hz_t hz_q16;
    logic nominal;

    modport regs (output trim, input offset, input ppm_q16, input hz_q16, input nominal);
    modport scaler (input trim, output offset, output ppm_q16, output hz_q16, output nominal);
endinterface

// [hdl/trim_scaler.sv]
`timescale 1ns/100ps
`include "trim_defines.svh"

module trim_scaler (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Trim in, scaled results out
    trim_if.scaler tr
);

    trim_pkg::offset_t offset_next;
    logic signed [29:0] ppm_next;
    logic signed [32:0] hz_next;

    // Unsigned trim minus nominal gives a signed offset
    always_comb begin
        offset_next = trim_pkg::offset_t'({1'b0, tr.trim} - `TRIM_NOMINAL);
        ppm_next = offset_next * `PPM_PER_LSB_Q16;
        hz_next = offset_next * `HZ_PER_LSB_Q16;
    end

    // One register stage; a full-width multiply is cheap at 50 MHz
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tr.offset <= '0;
            tr.ppm_q16 <= '0;
            tr.hz_q16 <= '0;
            tr.nominal <= 1'b1;
        end else begin
            tr.offset <= offset_next;
            tr.ppm_q16 <= ppm_next;
            tr.hz_q16 <= hz_next;
            tr.nominal <= (offset_next == '0);
        end
    end

endmodule

// [hdl/crystal_trim_registers.sv]
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "trim_defines.svh"

// How it works
// - Trim word is the high byte register over the low byte register.
// - Trim calibrates the 12.8 MHz crystal; an offset in Hz is derived.
// - An unsigned 16-bit trim spans +514 ppm down to -771 ppm.
// - Trim is unsigned; each step is 0.0196229 ppm.
// - Both trim byte registers are read/write and reset to 1001 1001.
module crystal_trim_registers #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Avalon-MM slave, byte addressed
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Calibration results for the synthesiser
    output trim_pkg::trim_t trim_value,
    output trim_pkg::offset_t trim_offset,
    output trim_pkg::ppm_t trim_ppm_q16,
    output trim_pkg::hz_t trim_hz_q16,
    output logic trim_nominal,
    // Manual holdover word, low byte
    output trim_pkg::byte_t holdover_low
);

    // Decode needs the highest index plus the word shift
    generate
        if (ADDR_W < 10) begin : g_addr_check
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] ADDR_LOW = ADDR_W'(`TRIM_IDX_LOW) << `TRIM_ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_HIGH = ADDR_W'(`TRIM_IDX_HIGH) << `TRIM_ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_HOLD = ADDR_W'(`TRIM_IDX_HOLD_LOW) << `TRIM_ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(`TRIM_IDX_STATUS) << `TRIM_ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] ADDR_PPM = ADDR_W'(`TRIM_IDX_PPM) << `TRIM_ADDR_SHIFT;

    trim_pkg::bus_state_t state_reg;
    trim_pkg::byte_t trim_low_reg;
    trim_pkg::byte_t trim_high_reg;
    trim_pkg::byte_t hold_low_reg;
    trim_pkg::trim_t trim_value_reg;
    trim_pkg::offset_t offset_reg;
    trim_pkg::ppm_t ppm_reg;
    trim_pkg::hz_t hz_reg;
    logic nominal_reg;
    logic results_valid_reg;
    logic waitrequest_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic request;
    logic accept;
    logic commit_write;
    logic trim_commit;

    trim_if tr ();

    // Scaling lives in its own module to keep the multipliers apart
    trim_scaler trim_scaler_inst (
        .clk(clk),
        .reset(reset),
        .tr(tr.scaler)
    );

    assign request = avs_read | avs_write;
    // Request seen in idle: latch read data, drop waitrequest next cycle
    assign accept = request & (state_reg == trim_pkg::BUS_IDLE);
    // Write lands on the edge where the master sees waitrequest low
    assign commit_write = avs_write & (state_reg == trim_pkg::BUS_DONE);
    // A lane 0 write that lands on one of the two trim bytes
    assign trim_commit = commit_write & avs_byteenable[0]
        & ((avs_address == ADDR_LOW) | (avs_address == ADDR_HIGH));

    // One wait cycle per access, so the master never samples stale data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= trim_pkg::BUS_IDLE;
        end else begin
            case (state_reg)
                trim_pkg::BUS_IDLE: begin
                    if (request) begin
                        state_reg <= trim_pkg::BUS_DONE;
                    end
                end
                trim_pkg::BUS_DONE: begin
                    state_reg <= trim_pkg::BUS_IDLE;
                end
                default: begin
                    state_reg <= trim_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Waitrequest high in reset and idle, low for the completing cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= ~accept;
        end
    end

    // Read mux; unmapped and reserved bits read as zero
    always_comb begin
        readdata_next = '0;
        if (avs_address == ADDR_LOW) begin
            readdata_next[7:0] = trim_low_reg;
        end else if (avs_address == ADDR_HIGH) begin
            readdata_next[7:0] = trim_high_reg;
        end else if (avs_address == ADDR_HOLD) begin
            readdata_next[7:0] = hold_low_reg;
        end else if (avs_address == ADDR_STATUS) begin
            readdata_next[16:0] = offset_reg;
            readdata_next[`STATUS_NOMINAL_BIT] = nominal_reg;
            readdata_next[`STATUS_VALID_BIT] = results_valid_reg;
        end else if (avs_address == ADDR_PPM) begin
            readdata_next = {{2{ppm_reg[29]}}, ppm_reg};
        end
    end

    // Read data captured at accept, stands through the done cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            readdata_reg <= '0;
        end else if (accept && avs_read) begin
            readdata_reg <= readdata_next;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trim_low_reg <= `TRIM_RESET_BYTE;
            trim_high_reg <= `TRIM_RESET_BYTE;
        end else if (commit_write && avs_byteenable[0]) begin
            if (avs_address == ADDR_LOW) begin
                trim_low_reg <= avs_writedata[7:0];
            end else if (avs_address == ADDR_HIGH) begin
                trim_high_reg <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_low_reg <= `HOLD_RESET_BYTE;
        end else if (commit_write && avs_byteenable[0] && avs_address == ADDR_HOLD) begin
            hold_low_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trim_value_reg <= {`TRIM_RESET_BYTE, `TRIM_RESET_BYTE};
        end else begin
            trim_value_reg[`TRIM_HIGH_MSB:`TRIM_HIGH_LSB] <= trim_high_reg;
            trim_value_reg[`TRIM_LOW_MSB:`TRIM_LOW_LSB] <= trim_low_reg;
        end
    end

    // unsigned trim goes to the scaler
    assign tr.trim = trim_value_reg;

    // results registered again so every output leaves a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            offset_reg <= '0;
            ppm_reg <= '0;
            hz_reg <= '0;
            nominal_reg <= 1'b1;
        end else begin
            offset_reg <= tr.offset;
            ppm_reg <= tr.ppm_q16;
            hz_reg <= tr.hz_q16;
            nominal_reg <= tr.nominal;
        end
    end

    // Results lag a byte write by several edges; valid only once every stage agrees,
    // so a stale offset never reads as valid while the new word is in flight
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            results_valid_reg <= 1'b1;
        end else begin
            results_valid_reg <= ~trim_commit
                & (trim_value_reg == {trim_high_reg, trim_low_reg})
                & (trim_value_reg == trim_pkg::trim_t'(offset_reg + `TRIM_NOMINAL));
        end
    end

    assign avs_waitrequest = waitrequest_reg;
    assign avs_readdata = readdata_reg;
    assign trim_value = trim_value_reg;
    assign trim_offset = offset_reg;
    assign trim_ppm_q16 = ppm_reg;
    assign trim_hz_q16 = hz_reg;
    assign trim_nominal = nominal_reg;
    assign holdover_low = hold_low_reg;

    // Checks on the design's outputs and internal registers
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_trim_concat: assert property (
        trim_value == {$past(trim_high_reg), $past(trim_low_reg)}
    ) else $error("trim word is not high byte over low byte");

    a_hz_scale: assert property (
        trim_hz_q16 == trim_offset * `HZ_PER_LSB_Q16
    ) else $error("Hz offset does not match trim offset");

    a_ppm_span: assert property (
        ($signed(trim_ppm_q16[29:16]) <= `PPM_MAX_INT)
        && ($signed(trim_ppm_q16[29:16]) >= `PPM_MIN_INT)
    ) else $error("ppm offset outside the crystal span");

    a_ppm_step: assert property (
        trim_ppm_q16 == trim_offset * `PPM_PER_LSB_Q16
    ) else $error("ppm offset not 1286 Q16 per step");

    a_offset_nominal: assert property (
        ##2 trim_offset == trim_pkg::offset_t'({1'b0, $past(trim_value, 2)} - `TRIM_NOMINAL)
    ) else $error("offset not trim minus 39321");

    a_trim_write: assert property (
        (commit_write && avs_byteenable[0] && avs_address == ADDR_HIGH)
        |=> trim_high_reg == $past(avs_writedata[7:0]) ##1 trim_value[15:8] == $past(avs_writedata[7:0], 2)
    ) else $error("trim high byte write lost");

    a_hold_write: assert property (
        (commit_write && avs_byteenable[0] && avs_address == ADDR_HOLD)
        |=> holdover_low == $past(avs_writedata[7:0])
    ) else $error("holdover low byte write lost");

    a_bus_wait: assert property (
        (request && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest
    ) else $error("waitrequest not one cycle");

    a_commit_wait: assert property (
        commit_write |-> !avs_waitrequest
    ) else $error("write landed while waitrequest high");

    a_read_low: assert property (
        (accept && avs_read && avs_address == ADDR_LOW)
        |=> avs_readdata == {24'h0, $past(trim_low_reg)}
    ) else $error("trim low byte read back wrong");

    a_read_high: assert property (
        (accept && avs_read && avs_address == ADDR_HIGH)
        |=> avs_readdata == {24'h0, $past(trim_high_reg)}
    ) else $error("trim high byte read back wrong");

    a_read_hold: assert property (
        (accept && avs_read && avs_address == ADDR_HOLD)
        |=> avs_readdata == {24'h0, $past(holdover_low)}
    ) else $error("holdover low byte read back wrong");

    a_read_status: assert property (
        (accept && avs_read && avs_address == ADDR_STATUS)
        |=> avs_readdata[16:0] == $past(trim_offset)
    ) else $error("status offset field read back wrong");

    a_read_ppm: assert property (
        (accept && avs_read && avs_address == ADDR_PPM)
        |=> avs_readdata == 32'($past(trim_ppm_q16))
    ) else $error("ppm register read back wrong");

    a_read_unmapped: assert property (
        (accept && avs_read && avs_address != ADDR_LOW && avs_address != ADDR_HIGH
            && avs_address != ADDR_HOLD && avs_address != ADDR_STATUS
            && avs_address != ADDR_PPM)
        |=> avs_readdata == '0
    ) else $error("unmapped address read nonzero");

    a_trim_steady: assert property (
        !trim_commit |=> $stable(trim_low_reg) && $stable(trim_high_reg)
    ) else $error("trim byte changed without a write");

    a_hold_steady: assert property (
        !(commit_write && avs_byteenable[0] && avs_address == ADDR_HOLD)
        |=> $stable(holdover_low)
    ) else $error("holdover low byte changed without a write");

    a_valid_drop: assert property (
        trim_commit |=> !results_valid_reg
    ) else $error("results valid stayed high across a trim write");

    c_trim_write: cover property (commit_write && avs_address == ADDR_LOW);
    c_status_read: cover property (accept && avs_read && avs_address == ADDR_STATUS);
    c_off_nominal: cover property ($fell(trim_nominal));
    c_ppm_read: cover property (accept && avs_read && avs_address == ADDR_PPM);
    c_hold_write: cover property (commit_write && avs_address == ADDR_HOLD);

endmodule

// [bench/crystal_trim_registers_bench.sv]
`timescale 1ns/100ps
`include "trim_defines.svh"

module crystal_trim_registers_bench;
    // Design ports
    logic clk;
    logic reset;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    trim_pkg::trim_t trim_value;
    trim_pkg::offset_t trim_offset;
    trim_pkg::ppm_t trim_ppm_q16;
    trim_pkg::hz_t trim_hz_q16;
    logic trim_nominal;
    trim_pkg::byte_t holdover_low;
    // Expected read data, oldest first
    logic [31:0] exp_q[$];
    int n_mismatch;
    int samples_checked;
    trim_pkg::trim_t cur;
    trim_pkg::byte_t hold;
    trim_pkg::ppm_t span;

    // Byte addresses: register index times four
    localparam logic [9:0] A_LOW = 10'(`TRIM_IDX_LOW) << `TRIM_ADDR_SHIFT;
    localparam logic [9:0] A_HIGH = 10'(`TRIM_IDX_HIGH) << `TRIM_ADDR_SHIFT;
    localparam logic [9:0] A_HOLD = 10'(`TRIM_IDX_HOLD_LOW) << `TRIM_ADDR_SHIFT;
    localparam logic [9:0] A_STAT = 10'(`TRIM_IDX_STATUS) << `TRIM_ADDR_SHIFT;
    localparam logic [9:0] A_PPM = 10'(`TRIM_IDX_PPM) << `TRIM_ADDR_SHIFT;

    crystal_trim_registers #(.ADDR_W(10)) crystal_trim_registers_inst (
        .clk(clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trim_value(trim_value), .trim_offset(trim_offset), .trim_ppm_q16(trim_ppm_q16),
        .trim_hz_q16(trim_hz_q16), .trim_nominal(trim_nominal), .holdover_low(holdover_low)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_out(input logic [63:0] got, input logic [63:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus_write(input logic [9:0] addr, input logic [7:0] data, input logic [3:0] be);
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= {24'($urandom()), data};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        @(posedge clk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_read(input logic [9:0] addr, input logic [31:0] exp);
        @(posedge clk);
        exp_q.push_back(exp);
        avs_address <= addr;
        avs_read <= 1'b1;
        @(posedge clk iff avs_waitrequest === 1'b0);
        avs_read <= 1'b0;
    endtask

    // Calibration outputs and the two result registers for a given trim
    task automatic cmp_cal(input trim_pkg::trim_t t);
        trim_pkg::offset_t off;
        trim_pkg::ppm_t ppm;
        trim_pkg::hz_t hz;
        off = $signed({1'b0, t}) - 17'sd39321;
        ppm = off * 30'sd1286;
        hz = off * 33'sd16461;
        cmp_out(64'(trim_value), 64'(t), "trim");
        cmp_out(64'(trim_offset), 64'(off), "offset");
        cmp_out(64'(trim_ppm_q16), 64'(ppm), "ppm");
        cmp_out(64'(trim_hz_q16), 64'(hz), "hz");
        cmp_out(64'(trim_nominal), 64'(off == 17'sd0), "nominal");
        bus_read(A_STAT, {1'b1, off == 17'sd0, 13'h0, off});
        bus_read(A_PPM, {{2{ppm[29]}}, ppm});
    endtask

    task automatic check_defaults();
        cmp_cal(16'h9999);
        bus_read(A_LOW, 32'h99);
        bus_read(A_HIGH, 32'h99);
        bus_read(A_HOLD, 32'h00);
        cmp_out(64'(holdover_low), 64'h0, "holdover");
    endtask

    // Monitor: each completed read takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("MISMATCH at %0t: read with nothing expected", $time);
            end else begin
                cmp_read(avs_readdata, exp_q.pop_front());
            end
        end
    end

    // Watchdog well beyond the expected run of about six hundred and thirty cycles
    initial begin
        #(20 * 20000);
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        void'($urandom(32'h5183));
        n_mismatch = 0;
        samples_checked = 0;
        reset = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        check_defaults();
        // Span ends first, then random trims in both write orders
        for (int i = 0; i < 16; i++) begin
            cur = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom());
            if (i[0]) begin
                bus_write(A_HIGH, cur[15:8], 4'hf);
                bus_write(A_LOW, cur[7:0], 4'h1);
            end else begin
                bus_write(A_LOW, cur[7:0], 4'hf);
                bus_write(A_HIGH, cur[15:8], 4'h1);
            end
            // Lane 0 off and unmapped writes must leave everything alone
            bus_write(A_LOW, ~cur[7:0], 4'he);
            bus_write(10'h3fc, ~cur[15:8], 4'hf);
            repeat (4) @(posedge clk);
            cmp_cal(cur);
            if (i < 2) begin
                span = trim_ppm_q16 / 30'sd65536;
                cmp_out(64'(span), (i == 0) ? -64'sd771 : 64'sd514, "span");
            end
            bus_read(A_LOW, {24'h0, cur[7:0]});
            bus_read(A_HIGH, {24'h0, cur[15:8]});
            bus_read(10'h3fc, 32'h0);
            hold = 8'($urandom());
            bus_write(A_HOLD, hold, 4'h1);
            bus_read(A_HOLD, {24'h0, hold});
            cmp_out(64'(holdover_low), 64'(hold), "holdover");
        end
        // Second reset in mid-run restores every default
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        check_defaults();
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule
